// file: shared/tts_pkg.sv
/*
 Constants, register map and types for the transfer test sequencer.
 Assumes a 10 MHz core clock and 32-bit Avalon-MM register access.
*/
package tts_pkg;
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned HOLD_MS = 2000;
    localparam int unsigned HOLD_CYC = HOLD_MS * (CLK_HZ / 1000);
    localparam int unsigned BLINK_HALF_MS = 250;
    localparam int unsigned BLINK_HALF_CYC = BLINK_HALF_MS * (CLK_HZ / 1000);
    localparam int unsigned FALLBACK_S = 120;
    localparam int unsigned FALLBACK_CYC = FALLBACK_S * CLK_HZ;
    localparam int unsigned TICK_MS = 100;
    localparam int unsigned TICK_CYC = TICK_MS * (CLK_HZ / 1000);
    localparam logic [7:0] PHASE_LIMIT_DEG = 8'd25;
    localparam logic [7:0] FREQ_LIMIT_CHZ = 8'd100;
    // Percent thresholds
    localparam logic [7:0] UTIL_PICK_HI = 8'd95;
    localparam logic [7:0] UTIL_PICK_LO = 8'd90;
    localparam logic [7:0] UTIL_DROP_0 = 8'd85;
    localparam logic [7:0] UTIL_DROP_1 = 8'd80;
    localparam logic [7:0] UTIL_DROP_2 = 8'd70;
    localparam logic [7:0] GEN_V_PICK = 8'd90;
    localparam logic [7:0] GEN_V_DROP = 8'd75;
    localparam logic [7:0] GEN_F_PICK = 8'd90;
    localparam logic [7:0] GEN_F_DROP = 8'd85;
    // Register byte addresses
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_ES = 8'h04;
    localparam logic [7:0] ADDR_NE = 8'h08;
    localparam logic [7:0] ADDR_EN = 8'h0c;
    localparam logic [7:0] ADDR_CD = 8'h10;
    localparam logic [7:0] ADDR_STAT = 8'h14;
    // Control field positions
    localparam int unsigned CTRL_LOADED = 0;
    localparam int unsigned CTRL_PHASE_EN = 1;
    localparam int unsigned CTRL_FALLBACK = 2;
    localparam int unsigned CTRL_EXT_EX = 3;
    localparam int unsigned CTRL_PICK_SEL = 4;
    localparam int unsigned CTRL_DROP_LSB = 5;
    localparam logic [15:0] DELAY_RST = 16'h000a;
    typedef enum logic [3:0] {
        TTS_IDLE, TTS_ACK, TTS_ES, TTS_WAIT_GEN, TTS_NE, TTS_PHASE, TTS_ON_GEN,
        TTS_EN, TTS_RETX, TTS_CD, TTS_NOLOAD
    } tts_state_t;
endpackage

// file: logic/tts_top.sv
/*
 Transfer test sequencer: operator test with or without load, source judging,
 phase-check gate and exerciser select, with an Avalon-MM register slave.
 Assumes panel and sensor inputs are asynchronous; levels are percent, phase difference in degrees, frequency difference in cHz.
*/
// The register addresses and the Avalon-MM register port are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module tts_top
    import tts_pkg::*;
#(
    parameter int unsigned NPH = 3,
    parameter logic EXT_EX_FACTORY = 1'b0,
    parameter int unsigned HOLD_CYCLES = HOLD_CYC,
    parameter int unsigned BLINK_CYCLES = BLINK_HALF_CYC,
    parameter int unsigned FALLBACK_CYCLES = FALLBACK_CYC,
    parameter int unsigned TICK_CYCLES = TICK_CYC
) (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic test_button,
    input wire logic remote_test_n,
    input wire logic override_req,
    input wire logic util_connected,
    input wire logic gen_connected,
    input wire logic [NPH*8-1:0] util_volt_pct,
    input wire logic [7:0] gen_volt_pct,
    input wire logic [7:0] gen_freq_pct,
    input wire logic [7:0] phase_diff_deg,
    input wire logic [7:0] freq_diff_chz,
    output logic start_relay,
    output logic transfer_cmd,
    output logic retransfer_cmd,
    output logic test_led,
    output logic util_avail_led,
    output logic gen_avail_led,
    output logic int_ex_en,
    output logic ext_ex_en
);
    localparam int unsigned NS = 6 + NPH * 8 + 8 * 5;

    typedef struct packed {
        logic [NS-1:0] s1;
        logic [NS-1:0] s2;
        logic [7:0] ctrl;
        logic [15:0] d_es;
        logic [15:0] d_ne;
        logic [15:0] d_en;
        logic [15:0] d_cd;
        logic [31:0] rdata;
        logic wait_n;
        tts_state_t st;
        logic [31:0] hold;
        logic [31:0] blink;
        logic blink_on;
        logic [31:0] ack;
        logic ack_lit;
        logic [31:0] tick;
        logic [15:0] dly;
        logic [31:0] fb;
        logic [7:0] ph_prev;
        logic btn_prev;
        logic rem_prev;
        logic util_ok;
        logic gen_ok;
        logic relay;
        logic xfer;
        logic rexfer;
        logic led;
    } tts_state_s_t;

    tts_state_s_t r_reg, r_next;

    // Hysteresis: up at or above pickup, down below dropout, else hold
    function automatic logic tts_hyst(input logic cur, input logic [7:0] v,
                                      input logic [7:0] pk, input logic [7:0] dr);
        logic res;
        res = cur;
        if (v >= pk) begin
            res = 1'b1;
        end else if (v < dr) begin
            res = 1'b0;
        end
        return res;
    endfunction

    logic [NS-1:0] raw;
    assign raw = {override_req, remote_test_n, test_button, util_connected, gen_connected,
                  1'b0, util_volt_pct, gen_volt_pct, gen_freq_pct, phase_diff_deg,
                  freq_diff_chz, 8'h00};

    always_comb begin
        logic ovr, rem_n, btn, uconn, gconn;
        logic [NPH*8-1:0] uv;
        logic [7:0] gv, gf, pd, fd, pick, drop;
        logic tick_p, dly_done, u_all_up, u_any_dn, test_act, test_end, phase_ok, ok_btn;
        r_next = r_reg;
        {ovr, rem_n, btn, uconn, gconn} = r_reg.s2[NS-1 -: 5];
        uv = r_reg.s2[NS-7 -: NPH*8];
        gv = r_reg.s2[39:32];
        gf = r_reg.s2[31:24];
        pd = r_reg.s2[23:16];
        fd = r_reg.s2[15:8];
        r_next.s1 = raw;
        r_next.s2 = r_reg.s1;

        // Avalon slave: one wait cycle, answer on the second
        r_next.wait_n = 1'b0;
        if ((avs_read || avs_write) && !r_reg.wait_n) begin
            r_next.wait_n = 1'b1;
            r_next.rdata = 32'h0000_0000;
            unique case (avs_address)
                ADDR_CTRL: r_next.rdata = {24'h000000, r_reg.ctrl};
                ADDR_ES: r_next.rdata = {16'h0000, r_reg.d_es};
                ADDR_NE: r_next.rdata = {16'h0000, r_reg.d_ne};
                ADDR_EN: r_next.rdata = {16'h0000, r_reg.d_en};
                ADDR_CD: r_next.rdata = {16'h0000, r_reg.d_cd};
                ADDR_STAT: r_next.rdata = {24'h000000, r_reg.gen_ok, r_reg.util_ok,
                                           r_reg.st, 2'b00};
                default: r_next.rdata = 32'h0000_0000;
            endcase
        end
        // Writes land on the edge where waitrequest is seen low
        if (avs_write && r_reg.wait_n) begin
            unique case (avs_address)
                ADDR_CTRL: r_next.ctrl = avs_writedata[7:0];
                ADDR_ES: r_next.d_es = avs_writedata[15:0];
                ADDR_NE: r_next.d_ne = avs_writedata[15:0];
                ADDR_EN: r_next.d_en = avs_writedata[15:0];
                ADDR_CD: r_next.d_cd = avs_writedata[15:0];
                default: r_next.ctrl = r_reg.ctrl;
            endcase
        end

        pick = r_reg.ctrl[CTRL_PICK_SEL] ? UTIL_PICK_LO : UTIL_PICK_HI;
        unique case (r_reg.ctrl[CTRL_DROP_LSB +: 2])
            2'd1: drop = UTIL_DROP_1;
            2'd2: drop = UTIL_DROP_2;
            default: drop = UTIL_DROP_0;
        endcase
        u_all_up = 1'b1;
        u_any_dn = 1'b0;
        for (int i = 0; i < NPH; i++) begin
            if (uv[i*8 +: 8] < pick) u_all_up = 1'b0;
            if (uv[i*8 +: 8] < drop) u_any_dn = 1'b1;
        end
        if (u_all_up) r_next.util_ok = 1'b1;
        else if (u_any_dn) r_next.util_ok = 1'b0;
        r_next.gen_ok = tts_hyst(r_reg.gen_ok && gv >= GEN_V_DROP, gv, GEN_V_PICK, GEN_V_DROP)
                        && tts_hyst(r_reg.gen_ok && gf >= GEN_F_DROP, gf, GEN_F_PICK,
                                    GEN_F_DROP);

        r_next.btn_prev = btn;
        r_next.rem_prev = rem_n;
        if (btn && r_reg.hold < HOLD_CYCLES) r_next.hold = r_reg.hold + 32'd1;
        else if (!btn) r_next.hold = 32'd0;
        test_act = (btn && r_reg.hold == HOLD_CYCLES - 1) || (!rem_n && r_reg.rem_prev);
        ok_btn = btn && !r_reg.btn_prev;
        test_end = ok_btn || (rem_n && !r_reg.rem_prev);

        // 100 ms tick for the delay registers
        tick_p = (r_reg.tick == TICK_CYCLES - 1);
        r_next.tick = tick_p ? 32'd0 : r_reg.tick + 32'd1;
        if (tick_p && r_reg.dly != 16'h0000) r_next.dly = r_reg.dly - 16'h0001;
        dly_done = (r_reg.dly == 16'h0000);

        if (r_reg.ack != 32'd0) begin
            r_next.ack = r_reg.ack - 32'd1;
            if (r_reg.blink == BLINK_CYCLES - 1) begin
                r_next.blink = 32'd0;
                r_next.blink_on = !r_reg.blink_on;
            end else begin
                r_next.blink = r_reg.blink + 32'd1;
            end
        end
        r_next.led = (r_reg.ack != 32'd0) ? r_reg.blink_on : r_reg.ack_lit;
        r_next.xfer = 1'b0;
        r_next.rexfer = 1'b0;
        phase_ok = pd < PHASE_LIMIT_DEG && pd <= r_reg.ph_prev && fd < FREQ_LIMIT_CHZ;
        r_next.ph_prev = pd;

        unique case (r_reg.st)
            TTS_IDLE: begin
                r_next.relay = 1'b1;
                // start only when connected to available utility
                if (test_act && uconn && r_reg.util_ok) begin
                    r_next.st = TTS_ACK;
                    r_next.ack = HOLD_CYCLES;
                    r_next.blink = 32'd0;
                    r_next.blink_on = 1'b1;
                    r_next.ack_lit = 1'b1;
                    if (r_reg.ctrl[CTRL_LOADED]) begin
                        r_next.st = TTS_ES;
                        r_next.dly = r_reg.d_es;
                    end else begin
                        r_next.st = TTS_NOLOAD;
                        r_next.relay = 1'b0;
                    end
                end
            end
            TTS_ES: if (dly_done || ovr) begin
                r_next.relay = 1'b0;
                r_next.st = TTS_WAIT_GEN;
            end
            TTS_WAIT_GEN: if (r_reg.gen_ok) begin
                r_next.st = TTS_NE;
                r_next.dly = r_reg.d_ne;
            end
            TTS_NE: if (dly_done || ovr) begin
                r_next.st = TTS_PHASE;
                r_next.fb = 32'd0;
            end
            TTS_PHASE: begin
                r_next.fb = r_reg.fb + 32'd1;
                if (!r_reg.ctrl[CTRL_PHASE_EN] || !r_reg.gen_ok || phase_ok
                    || (r_reg.ctrl[CTRL_FALLBACK] && r_reg.fb >= FALLBACK_CYCLES - 1)) begin
                    r_next.xfer = 1'b1;
                    r_next.st = TTS_ON_GEN;
                end
            end
            TTS_ON_GEN: if (test_end) begin
                r_next.st = TTS_EN;
                r_next.dly = r_reg.d_en;
                r_next.ack = HOLD_CYCLES;
                r_next.ack_lit = 1'b0;
            end
            TTS_EN: if (dly_done || ovr) begin
                r_next.rexfer = 1'b1;
                r_next.st = TTS_RETX;
            end
            TTS_RETX: if (uconn) begin
                r_next.st = TTS_CD;
                r_next.dly = r_reg.d_cd;
            end
            TTS_CD: if (dly_done) begin
                r_next.relay = 1'b1;
                r_next.st = TTS_IDLE;
            end
            TTS_NOLOAD: if (test_end) begin
                r_next.ack = HOLD_CYCLES;
                r_next.ack_lit = 1'b0;
                r_next.relay = 1'b1;
                r_next.st = TTS_IDLE;
            end
            default: r_next.st = TTS_IDLE;
        endcase

        // abort on utility loss: back to idle, engine stopped; a retransfer pulse set by TTS_EN in the same cycle is not cleared
        if (!r_reg.util_ok && r_reg.st != TTS_IDLE) begin
            r_next.st = TTS_IDLE;
            r_next.relay = 1'b1;
            r_next.ack = 32'd0;
            r_next.ack_lit = 1'b0;
            r_next.led = 1'b0;
        end
        if (srst) begin
            r_next = '0;
            r_next.st = TTS_IDLE;
            r_next.relay = 1'b1;
            r_next.d_es = DELAY_RST;
            r_next.d_ne = DELAY_RST;
            r_next.d_en = DELAY_RST;
            r_next.d_cd = DELAY_RST;
            r_next.ctrl[CTRL_EXT_EX] = EXT_EX_FACTORY;
        end
    end

    always_ff @(posedge core_clk) begin
        r_reg <= r_next;
    end

    assign avs_readdata = r_reg.rdata;
    assign avs_waitrequest = (avs_read || avs_write) && !r_reg.wait_n;
    assign start_relay = r_reg.relay;
    assign transfer_cmd = r_reg.xfer;
    assign retransfer_cmd = r_reg.rexfer;
    assign test_led = r_reg.led;
    assign util_avail_led = r_reg.util_ok;
    assign gen_avail_led = r_reg.gen_ok;
    assign int_ex_en = !r_reg.ctrl[CTRL_EXT_EX];
    assign ext_ex_en = r_reg.ctrl[CTRL_EXT_EX];
endmodule
`default_nettype wire

// file: verification/tts_monitor.sv
/*
 Port checker for the transfer test sequencer.
 Assumes it is bound to tts_top by the bench top file.
*/
`timescale 1ns/1ns
`default_nettype none
module tts_monitor (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    input wire logic transfer_cmd,
    input wire logic retransfer_cmd,
    input wire logic start_relay,
    input wire logic test_led,
    input wire logic util_avail_led,
    input wire logic gen_avail_led,
    input wire logic int_ex_en,
    input wire logic ext_ex_en
);
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (srst);
    a_bus_one_wait: assert property (
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("waitrequest longer than one cycle");
    a_bus_idle: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
        else $error("waitrequest without request");
    a_xfer_pulse: assert property (transfer_cmd |=> !transfer_cmd)
        else $error("transfer pulse too long");
    a_retx_pulse: assert property (retransfer_cmd |=> !retransfer_cmd)
        else $error("retransfer pulse too long");
    a_xfer_gen_ok: assert property (transfer_cmd |-> gen_avail_led && !start_relay)
        else $error("transfer without running genset");
    a_retx_util_ok: assert property (retransfer_cmd |-> util_avail_led)
        else $error("retransfer to bad utility");
    a_exer_single: assert property (int_ex_en != ext_ex_en)
        else $error("exerciser enables not exclusive");
    a_abort_loss: assert property ($fell(util_avail_led) |-> ##[0:3] (start_relay && !test_led))
        else $error("test not aborted on utility loss");
    a_start_util_ok: assert property ($rose(test_led) |-> util_avail_led)
        else $error("test started with bad utility");
endmodule
`default_nettype wire

// file: verification/tts_plant_model.sv
/*
 Genset, transfer switch and utility seen by the sequencer.
 Assumes levels are set by the bench; switch moves on each command pulse.
*/
`timescale 1ns/1ns
`default_nettype none
module tts_plant_model #(
    parameter int unsigned NPH = 3
) (
    input wire logic core_clk,
    input wire logic start_relay,
    input wire logic transfer_cmd,
    input wire logic retransfer_cmd,
    input wire logic [7:0] util_lvl,
    input wire logic [7:0] gen_v_lvl,
    input wire logic [7:0] gen_f_lvl,
    input wire logic phase_bad,
    output logic util_connected,
    output logic gen_connected,
    output logic [NPH*8-1:0] util_volt_pct,
    output logic [7:0] gen_volt_pct,
    output logic [7:0] gen_freq_pct,
    output logic [7:0] phase_diff_deg,
    output logic [7:0] freq_diff_chz
);
    logic [4:0] run_cnt = 5'h00;
    initial begin
        util_connected = 1'b1;
        gen_connected = 1'b0;
    end
    always @(posedge core_clk) begin
        // engine needs time to build output after the contact closes
        if (start_relay) begin
            run_cnt <= 5'h00;
        end else if (run_cnt != 5'h10) begin
            run_cnt <= run_cnt + 5'h01;
        end
        if (transfer_cmd) begin
            util_connected <= 1'b0;
            gen_connected <= 1'b1;
        end
        if (retransfer_cmd) begin
            util_connected <= 1'b1;
            gen_connected <= 1'b0;
        end
    end
    // A stopped engine gives nothing, not its last level
    assign gen_volt_pct = (run_cnt == 5'h10) ? gen_v_lvl : 8'h00;
    assign gen_freq_pct = (run_cnt == 5'h10) ? gen_f_lvl : 8'h00;
    assign util_volt_pct = {NPH{util_lvl}};
    // sources out of step or nearly in step
    assign phase_diff_deg = phase_bad ? 8'h28 : 8'h0a;
    assign freq_diff_chz = phase_bad ? 8'h96 : 8'h32;
endmodule
`default_nettype wire

// file: verification/tts_tb_top.sv
/*
 Bench top for the transfer test sequencer.
 Assumes shortened counts: hold 40, blink 5, fallback 100, tick 10.
*/
`timescale 1ns/1ns
`default_nettype none
module tts_tb_top;
    import tts_pkg::*;
    localparam int HOLD = 40;
    localparam logic [7:0] UV[10] = '{86, 84, 94, 96, 71, 69, 89, 91, 81, 79};
    localparam logic [7:0] GV[4] = '{76, 74, 89, 91};
    localparam logic [7:0] GF[4] = '{86, 84, 89, 91};
    localparam logic UE[10] = '{1, 0, 0, 1, 1, 0, 0, 1, 1, 0};
    logic core_clk = 1'b0, srst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
    logic [7:0] avs_address = 8'h00;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
    logic avs_waitrequest, test_button = 1'b0, remote_test_n = 1'b1, override_req = 1'b0;
    logic util_connected, gen_connected, start_relay, transfer_cmd, retransfer_cmd;
    logic test_led, util_avail_led, gen_avail_led, int_ex_en, ext_ex_en, phase_bad = 1'b0;
    logic [23:0] util_volt_pct;
    logic [7:0] gen_volt_pct, gen_freq_pct, phase_diff_deg, freq_diff_chz;
    logic [7:0] util_lvl = 8'h64, gen_v_lvl = 8'h64, gen_f_lvl = 8'h64;
    int miscompares = 0, checks_done = 0, n, tmo = 0, xfers = 0;
    tts_top #(.HOLD_CYCLES(HOLD), .BLINK_CYCLES(5), .FALLBACK_CYCLES(100), .TICK_CYCLES(10)) dut (
        .core_clk, .srst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
        .avs_waitrequest, .test_button, .remote_test_n, .override_req, .util_connected,
        .gen_connected, .util_volt_pct, .gen_volt_pct, .gen_freq_pct, .phase_diff_deg,
        .freq_diff_chz, .start_relay, .transfer_cmd, .retransfer_cmd, .test_led,
        .util_avail_led, .gen_avail_led, .int_ex_en, .ext_ex_en);
    tts_plant_model #(.NPH(3)) plant (
        .core_clk, .start_relay, .transfer_cmd, .retransfer_cmd, .util_lvl, .gen_v_lvl,
        .gen_f_lvl, .phase_bad, .util_connected, .gen_connected, .util_volt_pct,
        .gen_volt_pct, .gen_freq_pct, .phase_diff_deg, .freq_diff_chz);
    initial begin
        forever #50 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        xfers <= xfers + int'(transfer_cmd === 1'b1);
        tmo <= tmo + 1;
        if (tmo == 20000) begin
            miscompares++;
            test_done();
        end
    end
    task automatic test_done();
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cyc(input int c);
        repeat (c) @(posedge core_clk);
    endtask
    // Request held until waitrequest is seen low at a rising edge
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        forever begin
            @(posedge core_clk);
            if (avs_waitrequest === 1'b0) begin
                rd = avs_readdata;
                break;
            end
        end
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge core_clk);
    endtask
    function automatic logic pick(input int s);
        case (s)
            0: return start_relay;
            1: return transfer_cmd;
            default: return retransfer_cmd;
        endcase
    endfunction
    task automatic wait_for(input int s, input logic v);
        n = 0;
        while (pick(s) !== v) begin
            @(posedge core_clk);
            n++;
        end
    endtask
    task automatic blinks();
        logic l;
        n = 0;
        repeat (HOLD + 4) begin
            l = test_led;
            @(posedge core_clk);
            n += int'(test_led !== l);
        end
    endtask
    task automatic step(input int k, input logic [7:0] v, input logic e);
        if (k == 0) util_lvl <= v;
        else if (k == 1) gen_v_lvl <= v;
        else gen_f_lvl <= v;
        cyc(8);
        chk("avail", 32'(e), 32'(k == 0 ? util_avail_led : gen_avail_led));
    endtask
    initial begin
        cyc(5);
        srst <= 1'b0;
        cyc(2);
        chk("relay", 1, 32'(start_relay));
        chk("ext", 0, 32'(ext_ex_en));
        bus(0, ADDR_ES, 0);
        chk("es", 32'(DELAY_RST), rd);
        bus(0, 8'h20, 0);
        chk("unmapped", 0, rd);
        bus(1, ADDR_CTRL, 32'h8);
        chk("int", 0, 32'(int_ex_en));
        for (int i = 0; i < 10; i++) begin
            if (i == 4) bus(1, ADDR_CTRL, 32'h50);
            if (i == 8) bus(1, ADDR_CTRL, 32'h30);
            step(0, UV[i], UE[i]);
        end
        util_lvl <= 8'h64;
        bus(1, ADDR_CTRL, 32'h0);
        test_button <= 1'b1;
        cyc(20);
        test_button <= 1'b0;
        cyc(10);
        chk("short press", 1, 32'(start_relay));
        test_button <= 1'b1;
        wait_for(0, 1'b0);
        chk("hold", 1, 32'(n >= HOLD - 2 && n <= HOLD + 8));
        test_button <= 1'b0;
        blinks();
        chk("blinks", 1, 32'(n >= 6 && n <= 9));
        chk("led on", 1, 32'(test_led));
        for (int i = 0; i < 4; i++) step(1, GV[i], UE[i]);
        for (int i = 0; i < 4; i++) step(2, GF[i], UE[i]);
        test_button <= 1'b1;
        cyc(3);
        test_button <= 1'b0;
        blinks();
        chk("end blinks", 1, 32'(n >= 6 && n <= 9));
        chk("led off", 0, 32'(test_led));
        chk("relay off", 1, 32'(start_relay));
        chk("no xfer", 0, xfers);
        for (int a = 4; a <= 16; a += 4) bus(1, 8'(a), 32'h3);
        bus(1, ADDR_CTRL, 32'h1);
        remote_test_n <= 1'b0;
        wait_for(0, 1'b0);
        chk("es", 1, 32'(n >= 28 && n <= 50));
        chk("util led", 1, 32'(util_avail_led));
        wait_for(1, 1'b1);
        chk("ne", 1, 32'(n >= 44 && n <= 70));
        remote_test_n <= 1'b1;
        wait_for(2, 1'b1);
        chk("en", 1, 32'(n >= 28 && n <= 50));
        wait_for(0, 1'b1);
        chk("cd", 1, 32'(n >= 28 && n <= 50));
        override_req <= 1'b1;
        remote_test_n <= 1'b0;
        wait_for(0, 1'b0);
        chk("es skip", 1, 32'(n <= 12));
        wait_for(1, 1'b1);
        chk("ne skip", 1, 32'(n <= 30));
        remote_test_n <= 1'b1;
        wait_for(2, 1'b1);
        chk("en skip", 1, 32'(n <= 12));
        wait_for(0, 1'b1);
        chk("cd kept", 1, 32'(n >= 28));
        override_req <= 1'b0;
        bus(1, ADDR_CTRL, 32'h7);
        phase_bad <= 1'b1;
        remote_test_n <= 1'b0;
        wait_for(0, 1'b0);
        wait_for(1, 1'b1);
        chk("fallback", 1, 32'(n >= 135 && n <= 200));
        phase_bad <= 1'b0;
        remote_test_n <= 1'b1;
        wait_for(2, 1'b1);
        chk("in step", 1, 32'(n <= 60));
        wait_for(0, 1'b1);
        chk("xfers", 3, xfers);
        bus(1, ADDR_CTRL, 32'h0);
        remote_test_n <= 1'b0;
        wait_for(0, 1'b0);
        util_lvl <= 8'h32;
        wait_for(0, 1'b1);
        chk("abort", 1, 32'(n <= 12));
        chk("abort led", 0, 32'(test_led));
        remote_test_n <= 1'b1;
        cyc(4);
        remote_test_n <= 1'b0;
        cyc(HOLD + 20);
        chk("refused", 1, 32'(start_relay));
        test_done();
    end
endmodule
bind tts_top tts_monitor u_mon (
    .core_clk, .srst, .avs_read, .avs_write, .avs_waitrequest, .transfer_cmd,
    .retransfer_cmd, .start_relay, .test_led, .util_avail_led, .gen_avail_led,
    .int_ex_en, .ext_ex_en);
`default_nettype wire
